// ===== rtl/rx_jitter_attenuator.sv
// receive jitter attenuator with link operating-mode selection
`timescale 1ns/10ps
`default_nettype none
module rx_jitter_attenuator
  import rx_ja_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // recovered clock and data from clock recovery
  input wire logic rx_clk_i,
  input wire logic rx_data_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // towards line decoder
  output logic dec_valid_o,
  output rx_bit_t dec_bit_o,
  input wire logic dec_ready_i,
  // status
  output logic int_n_o,
  output op_mode_t op_mode_o
);

  // ========================================================================
  // state
  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat_s1;
    logic dat_s2;
    logic [7:0] mode;
    logic [7:0] cfg;
    logic irq_en;
    logic err;
    logic [6:0] meas;
    logic [7:0] rdata;
    logic int_n;
    op_mode_t op_mode;
    ja_state_t state;
    logic [127:0] mem;
    logic [6:0] wptr;
    logic [6:0] rptr;
    logic [7:0] cnt;
    logic [15:0] per;
    logic [9:0] gap;
    logic [9:0] tick;
  } ja_q_t;

  ja_q_t q;
  ja_q_t d;

  logic buf_ready;
  logic push_valid;
  rx_bit_t push_bit;
  logic wr_stb;
  logic rd_stb;
  logic do_rd;
  logic ovf;
  logic unf;
  logic clr;
  logic [7:0] depth;
  logic [7:0] half;
  logic [6:0] cur_gap;
  logic [3:0] loop_sh;

  // ========================================================================
  // next state
  always_comb
  begin
    logic [7:0] marg;
    logic [9:0] target;
    logic signed [16:0] diff;
    logic [6:0] mask;
    marg = margin_of(q.cfg[DEPTH_LSB +: 2]);
    loop_sh = SH_T1_HI;
    target = '0;
    diff = '0;
    mask = '0;
    d = q;
    push_valid = 1'b0;
    push_bit = '0;
    rd_stb = 1'b0;
    do_rd = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    depth = depth_of(q.cfg[DEPTH_LSB +: 2]); // RULE_05
    half = depth >> 1;
    mask = 7'(depth - 8'h01);

    // pin synchronisers
    d.clk_s1 = rx_clk_i;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.dat_s1 = rx_data_i;
    d.dat_s2 = q.dat_s1;
    wr_stb = q.clk_s2 && !q.clk_s3;

    // operating mode decode
    if (!q.mode[CARRIER_BIT])
      d.op_mode = OP_E1; // RULE_03
    else if (q.mode[USJ_BIT])
      d.op_mode = q.mode[FMT_LSB] ? OP_J1_ESF : OP_J1_SF; // RULE_02
    else
      d.op_mode = op_mode_t'({1'b0, q.mode[FMT_LSB +: 2]}); // RULE_01

    // corner selection
    if (q.op_mode == OP_E1)
      loop_sh = q.cfg[CORNER_BIT] ? SH_E1_LO : SH_E1_HI; // RULE_09
    else
      loop_sh = q.cfg[CORNER_BIT] ? SH_T1_LO : SH_T1_HI; // RULE_08

    // register access
    clr = reg_wr_i && reg_addr_i == OFS_IRQ_STAT && reg_wdata_i[JA_IRQ_BIT];
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_LINK_MODE: d.mode = reg_wdata_i;
        OFS_JA_CFG: d.cfg = {2'h0, reg_wdata_i[5:0]};
        OFS_IRQ_EN: d.irq_en = reg_wdata_i[JA_IRQ_BIT];
        default: d.mode = d.mode;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_LINK_MODE: d.rdata = q.mode;
        OFS_JA_CFG: d.rdata = q.cfg;
        OFS_IRQ_EN: d.rdata = {7'h00, q.irq_en};
        OFS_JIT_MEAS: d.rdata = {1'b0, q.meas};
        OFS_IRQ_STAT: d.rdata = {7'h00, q.err};
        default: d.rdata = 8'h00;
      endcase
    end

    // period estimate of the incoming clock
    if (q.gap != 10'h3ff)
      d.gap = q.gap + 10'h001;
    if (wr_stb)
    begin
      diff = 17'({1'b0, q.gap, 6'h00}) - 17'({1'b0, q.per});
      d.per = q.per + 16'(diff >>> loop_sh); // RULE_10
      d.gap = 10'h001;
    end

    // read rate with near-limit speed adjust
    target = q.per[15:PER_FRAC];
    if (q.cfg[LIMIT_BIT] && q.cnt >= depth - marg) // RULE_13 RULE_14
      target = target - 10'h001;
    else if (q.cfg[LIMIT_BIT] && q.cnt <= marg) // RULE_13 RULE_14
      target = target + 10'h001;

    if (!q.cfg[EN_BIT])
    begin
      // bypass straight to the decoder
      push_valid = wr_stb; // RULE_04
      push_bit = '{bypass: 1'b1, data: q.dat_s2};
      d.state = ST_BYPASS;
      d.wptr = '0;
      d.rptr = '0;
      d.cnt = '0;
      d.tick = '0;
    end
    else
    begin
      if (q.state == ST_RUN)
      begin
        d.tick = q.tick + 10'h001;
        rd_stb = q.tick + 10'h001 >= target; // RULE_07
      end
      else
        d.tick = '0;
      if (rd_stb)
        d.tick = '0;
      do_rd = rd_stb && buf_ready && q.cnt != 8'h00;
      unf = rd_stb && buf_ready && q.cnt == 8'h00;
      ovf = wr_stb && q.cnt >= depth && !do_rd;
      if (wr_stb && !ovf)
      begin
        d.mem[q.wptr] = q.dat_s2; // RULE_07
        d.wptr = (q.wptr + 7'h01) & mask;
      end
      if (do_rd)
      begin
        push_valid = 1'b1;
        push_bit = '{bypass: 1'b0, data: q.mem[q.rptr]};
        d.rptr = (q.rptr + 7'h01) & mask;
      end
      d.cnt = q.cnt + 8'(wr_stb && !ovf) - 8'(do_rd);
      case (q.state)
        ST_BYPASS: d.state = ST_FILL;
        ST_FILL:
          if (q.cnt >= half)
            d.state = ST_RUN; // RULE_06
        ST_RUN:
          if (ovf || unf)
          begin
            d.state = ST_FILL;
            d.rptr = d.wptr;
            d.cnt = '0;
          end
        default: d.state = ST_BYPASS;
      endcase
    end

    // pointer distance measurement
    cur_gap = (q.cnt > 8'h7f) ? 7'h7f : q.cnt[6:0];
    if (!q.cfg[MEAS_BIT])
      d.meas = cur_gap; // RULE_15
    else if (cur_gap > q.meas)
      d.meas = cur_gap; // RULE_16

    // sticky error flag, set wins over clear
    d.err = ovf || unf || (q.err && !clr); // RULE_11 RULE_17
    d.int_n = !(d.err && d.irq_en); // RULE_12
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.mode <= MODE_RST;
      q.cfg <= CFG_RST;
      q.irq_en <= IRQ_EN_RST;
      q.int_n <= 1'b1;
      q.op_mode <= OP_T1_SF;
      q.state <= ST_BYPASS;
      q.per <= PER_RST;
    end
    else
      q <= d;
  end

  // ========================================================================
  // output buffer
  jit_out_buffer u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_bit_i(push_bit),
    .in_ready_o(buf_ready),
    .out_valid_o(dec_valid_o),
    .out_bit_o(dec_bit_o),
    .out_ready_i(dec_ready_i)
  );

  assign reg_rdata_o = q.rdata;
  assign int_n_o = q.int_n;
  assign op_mode_o = q.op_mode;

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_t1_formats: assert property ( // RULE_01
    q.mode[CARRIER_BIT] && !q.mode[USJ_BIT] && q.mode[1:0] == 2'h2
    |=> q.op_mode == OP_DIGITAL_MUX_FORMAT)
    else $error("t1 digital mux format not selected");

  chk_japan_formats: assert property ( // RULE_02
    q.mode[CARRIER_BIT] && q.mode[USJ_BIT]
    |=> q.op_mode == OP_J1_SF || q.op_mode == OP_J1_ESF)
    else $error("japanese mode gave a t1-only format");

  chk_e1_select: assert property ( // RULE_03
    !q.mode[CARRIER_BIT] |=> q.op_mode == OP_E1)
    else $error("carrier 0 did not give e1 mode");

  chk_bypass_path: assert property ( // RULE_04
    !q.cfg[EN_BIT] && wr_stb
    |-> push_valid && push_bit.bypass && push_bit.data == q.dat_s2)
    else $error("bypass did not forward the bit");

  chk_fifo_bound: assert property ( // RULE_05
    q.cnt <= depth)
    else $error("fifo fill beyond depth");

  chk_fill_release: assert property ( // RULE_06
    q.cfg[EN_BIT] && q.state == ST_FILL && q.cnt >= half
    && !reg_wr_i |=> q.state == ST_RUN)
    else $error("reading did not start at half depth");

  chk_no_early_read: assert property ( // RULE_06
    q.state != ST_RUN |-> !do_rd)
    else $error("fifo read before half depth reached");

  chk_error_sets: assert property ( // RULE_11
    ovf || unf |=> q.err)
    else $error("overflow or underflow not flagged");

  chk_irq_pin: assert property ( // RULE_12
    q.err && q.irq_en |-> !int_n_o)
    else $error("interrupt pin not driven");

  chk_error_sticky: assert property ( // RULE_17
    q.err && !clr |=> q.err)
    else $error("error flag cleared without software");

  chk_live_gap: assert property ( // RULE_15
    !q.cfg[MEAS_BIT] && !reg_wr_i && q.cnt < 8'h80
    |=> q.meas == $past(q.cnt[6:0]))
    else $error("gap value not tracking distance");

  chk_peak_hold: assert property ( // RULE_16
    q.cfg[MEAS_BIT] && !reg_wr_i |=> q.meas >= $past(q.meas))
    else $error("peak hold value dropped");

  chk_corner_t1: assert property ( // RULE_08
    q.op_mode != OP_E1
    |-> loop_sh == (q.cfg[CORNER_BIT] ? SH_T1_LO : SH_T1_HI))
    else $error("t1 loop corner not applied");

  chk_corner_e1: assert property ( // RULE_09
    q.op_mode == OP_E1
    |-> loop_sh == (q.cfg[CORNER_BIT] ? SH_E1_LO : SH_E1_HI))
    else $error("e1 loop corner not applied");

  chk_period_hold: assert property ( // RULE_10
    !wr_stb |=> q.per == $past(q.per))
    else $error("period estimate moved without a bit");

  chk_near_empty: assert property ( // RULE_13 RULE_14
    q.cfg[EN_BIT] && q.cfg[LIMIT_BIT] && q.state == ST_RUN
    && q.cnt <= margin_of(q.cfg[DEPTH_LSB +: 2])
    && q.tick + 10'h001 <= q.per[15:PER_FRAC] |-> !rd_stb)
    else $error("read rate not slowed near empty");

  chk_near_full: assert property ( // RULE_13 RULE_14
    q.cfg[EN_BIT] && q.cfg[LIMIT_BIT] && q.state == ST_RUN
    && q.cnt >= depth - margin_of(q.cfg[DEPTH_LSB +: 2])
    && q.tick + 10'h002 >= q.per[15:PER_FRAC] |-> rd_stb)
    else $error("read rate not raised near full");

  chk_full_skip: assert property ( // RULE_07
    rd_stb && !buf_ready |-> !do_rd && !unf)
    else $error("read taken while output buffer full");

  chk_bypass_idle: assert property ( // RULE_04
    !q.cfg[EN_BIT] |=> q.cnt == 8'h00)
    else $error("fifo filled in bypass");

endmodule
`default_nettype wire

// ===== inc/rx_ja_pkg.sv
// constants, types and helpers of the receive jitter attenuator
// ==========================================================================
// How it works
// [RULE_01] carrier 1 and us/japan 0 select sf, esf, digital mux or 96 loop carrier format by the frame format field.
// [RULE_02] carrier 1 and us/japan 1 give japanese mode with only sf or esf format.
// [RULE_03] carrier 0 gives e1 mode, ignoring us/japan and frame format; each link is set up on its own.
// [RULE_04] an enable bit puts the attenuator in the receive path or bypasses it.
// [RULE_05] a two-bit field sets the fifo depth to 32, 64 or 128 bits.
// [RULE_06] the attenuator adds a constant latency of half the fifo depth.
// [RULE_07] jittered data is written into the fifo and read out on a de-jittered clock from a digital pll.
// [RULE_08] in t1 or japanese mode the corner bit picks a 5 hz or 1.26 hz pll corner.
// [RULE_09] in e1 mode the corner bit picks a 6.77 hz or 0.87 hz pll corner.
// [RULE_10] the pll smooths only jitter above the corner and lets slower wander pass.
// [RULE_11] fifo overflow or underflow sets the fifo error flag.
// [RULE_12] the low-active interrupt pin is driven while the error flag and its enable are both set.
// [RULE_13] the limit enable makes the read rate adjust itself when the fifo nears full or empty.
// [RULE_14] adjustment starts 2, 3 or 4 bits from full or empty for depths 32, 64, 128.
// [RULE_15] measure select 0 writes the current pointer distance into the 7-bit gap value.
// [RULE_16] measure select 1 keeps the larger of the stored and current distance.
// [RULE_17] the error flag stays set until software clears it in the status register.
package rx_ja_pkg;

  // ========================================================================
  // register offsets
  localparam logic [7:0] OFS_LINK_MODE = 8'h20;
  localparam logic [7:0] OFS_JA_CFG = 8'h27;
  localparam logic [7:0] OFS_IRQ_EN = 8'h34;
  localparam logic [7:0] OFS_JIT_MEAS = 8'h39;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h3b;

  // ========================================================================
  // field positions
  localparam int FMT_LSB = 0;
  localparam int USJ_BIT = 2;
  localparam int CARRIER_BIT = 3;
  localparam int EN_BIT = 0;
  localparam int DEPTH_LSB = 1;
  localparam int CORNER_BIT = 3;
  localparam int LIMIT_BIT = 4;
  localparam int MEAS_BIT = 5;
  localparam int JA_IRQ_BIT = 0;

  // ========================================================================
  // reset values
  localparam logic [7:0] MODE_RST = 8'h08;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic IRQ_EN_RST = 1'b0;

  // ========================================================================
  // depth codes and near-limit margins
  localparam logic [1:0] DP_32 = 2'h0;
  localparam logic [1:0] DP_64 = 2'h1;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] MARG_32 = 8'h02;
  localparam logic [7:0] MARG_64 = 8'h03;
  localparam logic [7:0] MARG_128 = 8'h04;

  // ========================================================================
  // pll: corners in centihertz and the loop shift that sets each
  localparam int CF_T1_HI_CHZ = 500;
  localparam int CF_T1_LO_CHZ = 126;
  localparam int CF_E1_HI_CHZ = 677;
  localparam int CF_E1_LO_CHZ = 87;
  localparam logic [3:0] SH_T1_HI = 4'h8;
  localparam logic [3:0] SH_T1_LO = 4'ha;
  localparam logic [3:0] SH_E1_HI = 4'h8;
  localparam logic [3:0] SH_E1_LO = 4'hb;
  localparam int CLK_HZ = 10_000_000;
  localparam int LINE_HZ = 1_544_000;
  localparam int PER_FRAC = 6;
  localparam logic [15:0] PER_RST = 16'((CLK_HZ / LINE_HZ) << PER_FRAC);

  // ========================================================================
  // types
  typedef enum logic [2:0] {
    OP_T1_SF = 3'h0, OP_T1_ESF = 3'h1, OP_DIGITAL_MUX_FORMAT = 3'h2, OP_T1_LC96 = 3'h3,
    OP_J1_SF = 3'h4, OP_J1_ESF = 3'h5, OP_E1 = 3'h6
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_BYPASS = 3'b001, ST_FILL = 3'b010, ST_RUN = 3'b100
  } ja_state_t;

  typedef struct packed {
    logic bypass;
    logic data;
  } rx_bit_t;

  // ========================================================================
  // helpers
  function automatic logic [7:0] depth_of(input logic [1:0] sel);
    depth_of = (sel == DP_32) ? DEPTH_32 : (sel == DP_64) ? DEPTH_64
                                                          : DEPTH_128;
  endfunction

  function automatic logic [7:0] margin_of(input logic [1:0] sel);
    margin_of = (sel == DP_32) ? MARG_32 : (sel == DP_64) ? MARG_64
                                                          : MARG_128;
  endfunction

endpackage

// ===== rtl/jit_out_buffer.sv
// two-entry output buffer between attenuator and line decoder
`timescale 1ns/10ps
`default_nettype none
module jit_out_buffer
  import rx_ja_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  input wire rx_bit_t in_bit_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output rx_bit_t out_bit_o,
  input wire logic out_ready_i
);

  typedef struct packed {
    logic v0;
    rx_bit_t d0;
    logic v1;
    rx_bit_t d1;
  } buf_state_t;

  buf_state_t q;
  buf_state_t d;

  always_comb
  begin
    d = q;
    if (q.v0 && out_ready_i)
    begin
      d.v0 = q.v1;
      d.d0 = q.d1;
      d.v1 = 1'b0;
    end
    if (in_valid_i && !q.v1)
    begin
      if (!d.v0)
      begin
        d.v0 = 1'b1;
        d.d0 = in_bit_i;
      end
      else
      begin
        d.v1 = 1'b1;
        d.d1 = in_bit_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign in_ready_o = !q.v1;
  assign out_valid_o = q.v0;
  assign out_bit_o = q.d0;

endmodule
`default_nettype wire

// ===== verif/rx_line_partner.sv
// far-side model: recovered bit source and line decoder sink
`timescale 1ns/10ps
`default_nettype none
module rx_line_partner
(
  // control
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic stall_i,
  // line side
  output logic rx_clk_o,
  output logic rx_data_o,
  output logic [15:0] sent_o,
  // decoder side
  output logic dec_ready_o
);
  // ==========================================================================
  // bit source: 6 cycles a bit, clock still between frames
  logic [2:0] ph_q = 3'h0;
  logic clk_q = 1'b0;
  logic dat_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;

  assign rx_clk_o = clk_q;
  assign rx_data_o = dat_q;
  assign sent_o = cnt_q;
  assign dec_ready_o = !stall_i;

  always @(posedge clk_i)
  begin
    if (run_i || ph_q != 3'h0)
    begin
      ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
      if (ph_q == 3'h0)
        dat_q <= ^(cnt_q & 16'h002d);
      if (ph_q == 3'h2)
      begin
        clk_q <= 1'b1;
        cnt_q <= cnt_q + 16'h0001;
      end
      if (ph_q == 3'h5)
        clk_q <= 1'b0;
    end
    else
      dat_q <= !dat_q;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench of the receive jitter attenuator
`timescale 1ns/10ps
`default_nettype none
module tb
  import rx_ja_pkg::*;
;
  // ==========================================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic dec_valid_o;
  rx_bit_t dec_bit_o;
  logic dec_ready;
  logic int_n_o;
  op_mode_t op_mode_o;
  logic rx_clk;
  logic rx_data;
  logic run = 1'b0;
  logic stall = 1'b0;
  logic [15:0] sent;
  rx_bit_t got[$];
  int n_fail = 0;
  int samples_checked = 0;

  always #50 clk_i = !clk_i;

  rx_jitter_attenuator uut
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_clk_i(rx_clk),
    .rx_data_i(rx_data),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .dec_valid_o(dec_valid_o),
    .dec_bit_o(dec_bit_o),
    .dec_ready_i(dec_ready),
    .int_n_o(int_n_o),
    .op_mode_o(op_mode_o)
  );

  rx_line_partner far
  (
    .clk_i(clk_i),
    .run_i(run),
    .stall_i(stall),
    .rx_clk_o(rx_clk),
    .rx_data_o(rx_data),
    .sent_o(sent),
    .dec_ready_o(dec_ready)
  );

  always @(posedge clk_i)
  begin
    if (dec_valid_o === 1'b1 && dec_ready === 1'b1)
      got.push_back(dec_bit_o);
  end

  // ==========================================================================
  // helpers
  function automatic logic pat(input int n);
    pat = ^(16'(n) & 16'h002d);
  endfunction

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expire(input int k, input int lim);
    if (k >= lim)
    begin
      n_fail++;
      $display("CHECK FAILED %0t wait limit ran out", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] a[5] = '{OFS_LINK_MODE, OFS_JA_CFG, OFS_IRQ_EN,
                         OFS_IRQ_STAT, OFS_JIT_MEAS};
    logic [7:0] e[5] = '{MODE_RST, CFG_RST, 8'h00, 8'h00, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 5; i++)
    begin
      rd(a[i], v);
      check(v, e[i]);
    end
    wr(8'h50, 8'hff);
    rd(8'h50, v);
    check(v, 8'h00);
    wr(OFS_JIT_MEAS, 8'h7f);
    rd(OFS_JIT_MEAS, v);
    check(v, 8'h00);
  endtask

  task automatic t_modes();
    logic [7:0] mv[10] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
                           8'h0d, 8'h0e, 8'h0f, 8'h00, 8'h07};
    op_mode_t me[10] = '{OP_T1_SF, OP_T1_ESF, OP_DIGITAL_MUX_FORMAT, OP_T1_LC96,
                         OP_J1_SF, OP_J1_ESF, OP_J1_SF, OP_J1_ESF,
                         OP_E1, OP_E1};
    logic [7:0] v;
    for (int i = 0; i < 10; i++)
    begin
      wr(OFS_LINK_MODE, mv[i]);
      @(posedge clk_i);
      #1;
      check(8'(op_mode_o), 8'(me[i]));
      rd(OFS_LINK_MODE, v);
      check(v, mv[i]);
    end
    wr(OFS_LINK_MODE, MODE_RST);
  endtask

  task automatic t_bypass();
    int k;
    int base;
    wr(OFS_JA_CFG, 8'h00);
    got.delete();
    base = sent;
    run <= 1'b1;
    for (k = 0; k < 400 && sent < base + 24; k++)
      @(posedge clk_i);
    expire(k, 400);
    run <= 1'b0;
    repeat (20) @(posedge clk_i);
    check(8'(got.size()), 8'(sent - base));
    for (int i = 0; i < got.size(); i++)
      check(8'(got[i]), {6'h00, 1'b1, pat(base + i)});
  endtask

  task automatic t_atten();
    int k;
    int base;
    int half;
    logic [7:0] v;
    for (int d = 0; d < 3; d++)
    begin
      half = 16 << d;
      wr(OFS_JA_CFG, 8'h21 | 8'(d << 1) | 8'(d << 3));
      wr(OFS_IRQ_STAT, 8'h01);
      got.delete();
      base = sent;
      run <= 1'b1;
      for (k = 0; k < 2000 && got.size() == 0; k++)
        @(posedge clk_i);
      expire(k, 2000);
      check(8'((sent - base - half) inside {[0:2]}), 8'h01);
      stall <= 1'b1;
      repeat (20) @(posedge clk_i);
      stall <= 1'b0;
      for (k = 0; k < 3000 && sent < base + half + 40; k++)
        @(posedge clk_i);
      expire(k, 3000);
      run <= 1'b0;
      v = 8'h00;
      for (k = 0; k < 400 && v[0] !== 1'b1; k++)
        rd(OFS_IRQ_STAT, v);
      expire(k, 400);
      check(v, 8'h01);
      check(8'(got.size()), 8'(sent - base));
      for (int i = 0; i < got.size(); i++)
        check(8'(got[i]), {7'h00, pat(base + i)});
      rd(OFS_JIT_MEAS, v);
      check(8'(v >= half && v < half + 10), 8'h01);
      wr(OFS_JA_CFG, 8'h01 | 8'(d << 1));
      rd(OFS_JIT_MEAS, v);
      check(v, 8'h00);
    end
  endtask

  task automatic t_irq();
    logic [7:0] v;
    wr(OFS_IRQ_STAT, 8'h00);
    rd(OFS_IRQ_STAT, v);
    check(v, 8'h01);
    check(8'(int_n_o), 8'h01);
    wr(OFS_IRQ_EN, 8'h01);
    @(posedge clk_i);
    #1;
    check(8'(int_n_o), 8'h00);
    wr(OFS_IRQ_STAT, 8'h01);
    @(posedge clk_i);
    #1;
    check(8'(int_n_o), 8'h01);
    rd(OFS_IRQ_STAT, v);
    check(v, 8'h00);
  endtask

  task automatic t_ovf();
    int k;
    logic [7:0] v;
    wr(OFS_JA_CFG, 8'h01);
    wr(OFS_IRQ_STAT, 8'h01);
    stall <= 1'b1;
    run <= 1'b1;
    for (k = 0; k < 1000 && int_n_o !== 1'b0; k++)
      @(posedge clk_i);
    expire(k, 1000);
    run <= 1'b0;
    stall <= 1'b0;
    rd(OFS_IRQ_STAT, v);
    check(v, 8'h01);
    check(8'(int_n_o), 8'h00);
    repeat (20) @(posedge clk_i);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_modes();
    t_bypass();
    t_atten();
    t_irq();
    t_ovf();
    conclude();
  end
endmodule
`default_nettype wire
